/* verilog/ntl_exec.v */
// execution datapath for nibble swap, test-under-mask ops, xor and wait
//
// Overview of operation
// - swap writes nibble-exchanged byte; F0/F1, four cycles
// - swap: zero and sign from result
// - complement mask test ands inverted dst, no write
// - complement mask test: z, s set, v cleared
// - complement mask test opcodes 62-66, bytes, cycles
// - mask test ands dst with mask, no write
// - mask test opcodes 72-76, bytes and cycles
// - wait stalls cpu, dma keeps running
// - interrupt ends wait; flags unchanged
// - xor stores dst xor src; B2-B6
// - xor: z, s set, v cleared, rest kept
`timescale 1ns/1ps
`default_nettype none
`include "ntl_regs.vh"
module ntl_exec (
    // clock and reset
    input wire ref_clk_in,
    input wire rst_n_in,
    // instruction from sequencer
    input wire start_in,
    input wire [7:0] opcode_in,
    input wire [7:0] dst_data_in,
    input wire [7:0] src_data_in,
    // interrupt and dma
    input wire int_req_in,
    input wire dma_req_in,
    // flag register
    input wire [7:0] flags_in,
    // result to register file and flags
    output reg [7:0] result_out,
    output reg wr_en_out,
    output reg [7:0] flags_out,
    output reg flags_we_out,
    output reg done_out,
    // decode info for sequencer
    output wire [1:0] bytes_out,
    output wire src_first_out,
    output wire indirect_out,
    output wire immediate_out,
    output wire illegal_out,
    // status
    output wire busy_out,
    output wire cpu_stall_out,
    output wire dma_grant_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_EXEC = 2'h1;
    localparam ST_WAIT = 2'h2;
    // operation classes as coded by the decoder
    localparam CLS_SWAP = 3'h0;
    localparam CLS_CMASK = 3'h1;
    localparam CLS_MASK = 3'h2;
    localparam CLS_XOR = 3'h3;
    localparam CLS_WAIT = 3'h4;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [2:0] cnt_r;
    reg [2:0] cnt_nxt;
    reg [7:0] res_r;
    reg wr_r;
    reg [7:0] flg_r;
    reg int_s1_r;
    reg int_s2_r;
    reg dma_s1_r;
    reg dma_s2_r;
    wire [2:0] dec_class;
    wire [2:0] dec_cycles;
    wire dec_valid;
    wire issue;
    reg [7:0] res_c;
    reg wr_c;
    reg [7:0] flg_c;

    ntl_decode u_dec (
        .opcode_in(opcode_in),
        .op_class_out(dec_class),
        .bytes_out(bytes_out),
        .cycles_out(dec_cycles),
        .src_first_out(src_first_out),
        .indirect_out(indirect_out),
        .immediate_out(immediate_out),
        .valid_out(dec_valid)
    );

    // z and s from a value, v cleared or kept, others kept
    function [7:0] zs_flags;
        input [7:0] old;
        input [7:0] val;
        input clr_v;
        begin
            zs_flags = old;
            zs_flags[`NTL_FLAG_Z] = (val == 8'h00);
            zs_flags[`NTL_FLAG_S] = val[7];
            if (clr_v) begin
                zs_flags[`NTL_FLAG_V] = 1'b0;
            end
        end
    endfunction

    // result and flag computation
    always @* begin
        res_c = dst_data_in;
        wr_c = 1'b0;
        flg_c = flags_in;
        case (dec_class)
            CLS_SWAP: begin
                res_c = {dst_data_in[3:0], dst_data_in[7:4]};
                wr_c = 1'b1;
                flg_c = zs_flags(flags_in, res_c, 1'b0);
            end
            CLS_CMASK: begin
                res_c = (~dst_data_in) & src_data_in;
                flg_c = zs_flags(flags_in, res_c, 1'b1);
            end
            CLS_MASK: begin
                res_c = dst_data_in & src_data_in;
                flg_c = zs_flags(flags_in, res_c, 1'b1);
            end
            CLS_XOR: begin
                res_c = dst_data_in ^ src_data_in;
                wr_c = 1'b1;
                flg_c = zs_flags(flags_in, res_c, 1'b1);
            end
            default: flg_c = flags_in;
        endcase
    end

    // next state
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (issue) begin
                    // counter holds cycles-1 so done lands on the last cycle
                    cnt_nxt = dec_cycles - 3'h1;
                    if (dec_class == CLS_WAIT) begin
                        state_nxt = ST_WAIT;
                    end else begin
                        state_nxt = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                cnt_nxt = cnt_r - 3'h1;
                if (cnt_r == 3'h1) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (int_s2_r) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // two-flop synchronisers: interrupt and dma arrive from other domains
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            int_s1_r <= 1'b0;
            int_s2_r <= 1'b0;
            dma_s1_r <= 1'b0;
            dma_s2_r <= 1'b0;
        end else begin
            int_s1_r <= int_req_in;
            int_s2_r <= int_s1_r;
            dma_s1_r <= dma_req_in;
            dma_s2_r <= dma_s1_r;
        end
    end

    // operands and flags are captured at issue, so later input changes are ignored
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
            res_r <= 8'h00;
            wr_r <= 1'b0;
            flg_r <= `NTL_FLAGS_RST;
            result_out <= 8'h00;
            wr_en_out <= 1'b0;
            flags_out <= `NTL_FLAGS_RST;
            flags_we_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            wr_en_out <= 1'b0;
            flags_we_out <= 1'b0;
            done_out <= 1'b0;
            if (issue) begin
                res_r <= res_c;
                wr_r <= wr_c;
                flg_r <= flg_c;
            end
            if (state_r == ST_EXEC && cnt_r == 3'h1) begin
                result_out <= res_r;
                wr_en_out <= wr_r;
                flags_out <= flg_r;
                flags_we_out <= 1'b1;
                done_out <= 1'b1;
            end
            if (state_r == ST_WAIT && int_s2_r) begin
                done_out <= 1'b1;
            end
        end
    end

    assign issue = (state_r == ST_IDLE) && start_in && dec_valid;
    assign busy_out = (state_r != ST_IDLE);
    // dma is held off only while a datapath op is in flight
    assign cpu_stall_out = (state_r == ST_WAIT);
    assign dma_grant_out = dma_s2_r && (state_r != ST_EXEC);
    assign illegal_out = start_in && !dec_valid && (state_r == ST_IDLE);
endmodule // ntl_exec
`default_nettype wire

/* verilog/ntl_regs.vh */
// opcode, flag and timing constants for the nibble/test/logic datapath
`ifndef NTL_REGS_VH
`define NTL_REGS_VH
`define NTL_OP_SWAP_R 8'hF0
`define NTL_OP_SWAP_IR 8'hF1
`define NTL_OP_CMPL_MASK_RR 8'h62
`define NTL_OP_CMPL_MASK_RIR 8'h63
`define NTL_OP_CMPL_MASK_LRR 8'h64
`define NTL_OP_CMPL_MASK_LRIR 8'h65
`define NTL_OP_CMPL_MASK_IM 8'h66
`define NTL_OP_MASK_TEST_RR 8'h72
`define NTL_OP_MASK_TEST_RIR 8'h73
`define NTL_OP_MASK_TEST_LRR 8'h74
`define NTL_OP_MASK_TEST_LRIR 8'h75
`define NTL_OP_MASK_TEST_IM 8'h76
`define NTL_OP_XOR_RR 8'hB2
`define NTL_OP_XOR_RIR 8'hB3
`define NTL_OP_XOR_LRR 8'hB4
`define NTL_OP_XOR_LRIR 8'hB5
`define NTL_OP_XOR_IM 8'hB6
`define NTL_OP_WAIT 8'h3F
`define NTL_FLAG_C 7
`define NTL_FLAG_Z 6
`define NTL_FLAG_S 5
`define NTL_FLAG_V 4
`define NTL_FLAG_D 3
`define NTL_FLAG_H 2
`define NTL_CYC_SHORT 3'h4
`define NTL_CYC_LONG 3'h6
`define NTL_BYTES_ONE 2'h1
`define NTL_BYTES_TWO 2'h2
`define NTL_BYTES_THREE 2'h3
`define NTL_FLAGS_RST 8'h00
`endif

/* verilog/ntl_decode.v */
// opcode decoder: operation class, byte count, cycle count, operand order
`timescale 1ns/1ps
`default_nettype none
`include "ntl_regs.vh"
module ntl_decode (
    // opcode
    input wire [7:0] opcode_in,
    // decoded attributes
    output reg [2:0] op_class_out,
    output reg [1:0] bytes_out,
    output reg [2:0] cycles_out,
    output reg src_first_out,
    output reg indirect_out,
    output reg immediate_out,
    output reg valid_out
);
    // class codes: 0 swap, 1 complement mask test, 2 mask test, 3 xor, 4 wait
    always @* begin
        op_class_out = 3'h0;
        bytes_out = `NTL_BYTES_TWO;
        cycles_out = `NTL_CYC_SHORT;
        src_first_out = 1'b0;
        indirect_out = 1'b0;
        immediate_out = 1'b0;
        valid_out = 1'b1;
        case (opcode_in)
            `NTL_OP_SWAP_R: op_class_out = 3'h0;
            `NTL_OP_SWAP_IR: begin
                op_class_out = 3'h0;
                indirect_out = 1'b1;
            end
            `NTL_OP_WAIT: begin
                op_class_out = 3'h4;
                bytes_out = `NTL_BYTES_ONE;
            end
            default: begin
                case (opcode_in[7:4])
                    4'h6: op_class_out = 3'h1;
                    4'h7: op_class_out = 3'h2;
                    4'hB: op_class_out = 3'h3;
                    default: valid_out = 1'b0;
                endcase
                case (opcode_in[3:0])
                    4'h2: cycles_out = `NTL_CYC_SHORT;
                    4'h3: begin
                        cycles_out = `NTL_CYC_LONG;
                        indirect_out = 1'b1;
                    end
                    4'h4: begin
                        bytes_out = `NTL_BYTES_THREE;
                        cycles_out = `NTL_CYC_LONG;
                        src_first_out = 1'b1;
                    end
                    4'h5: begin
                        bytes_out = `NTL_BYTES_THREE;
                        cycles_out = `NTL_CYC_LONG;
                        src_first_out = 1'b1;
                        indirect_out = 1'b1;
                    end
                    4'h6: begin
                        bytes_out = `NTL_BYTES_THREE;
                        cycles_out = `NTL_CYC_LONG;
                        immediate_out = 1'b1;
                    end
                    default: valid_out = 1'b0;
                endcase
            end
        endcase
    end
endmodule // ntl_decode
`default_nettype wire

/* dv/ntl_exec_chk.sv */
// assertion checker for the nibble/test/logic datapath
`timescale 1ns/1ps
`default_nettype none
module ntl_exec_chk (
    input wire logic ref_clk_in, rst_n_in, start_in, int_req_in, dma_req_in, busy_out,
    input wire logic [7:0] opcode_in, dst_data_in, src_data_in, flags_in, result_out, flags_out,
    input wire logic wr_en_out, flags_we_out, done_out, cpu_stall_out, dma_grant_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire go = start_in && !busy_out;
    wire sh = go && opcode_in inside {8'hF0, 8'hF1, 8'h62, 8'h72, 8'hB2};
    wire lg = go && opcode_in[3:0] inside {[4'h3:4'h6]} && opcode_in[7:4] inside {4'h6, 4'h7, 4'hB};
    property p_short;
        sh |=> !done_out [*3] ##1 done_out;
    endproperty
    a_short: assert property (p_short) else $error("short op not done in 4");
    property p_long;
        lg |=> !done_out [*5] ##1 done_out;
    endproperty
    a_long: assert property (p_long) else $error("long op not done in 6");
    property p_swap;
        logic [7:0] d, f;
        (go && opcode_in[7:1] == 7'h78, d = dst_data_in, f = flags_in) |-> ##4 wr_en_out &&
            result_out == {d[3:0], d[7:4]} && flags_out[7:2] == {f[7], d == 8'h00, d[3], f[4:2]};
    endproperty
    a_swap: assert property (p_swap) else $error("swap result or flags");
    property p_cmask;
        logic [7:0] r, f;
        (go && opcode_in == 8'h62, r = ~dst_data_in & src_data_in, f = flags_in) |-> ##4
            !wr_en_out && flags_out[7:2] == {f[7], r == 8'h00, r[7], 1'b0, f[3:2]};
    endproperty
    a_cmask: assert property (p_cmask) else $error("complement test flags");
    property p_mask;
        logic [7:0] r, f;
        (go && opcode_in == 8'h72, r = dst_data_in & src_data_in, f = flags_in) |-> ##4
            !wr_en_out && flags_out[7:2] == {f[7], r == 8'h00, r[7], 1'b0, f[3:2]};
    endproperty
    a_mask: assert property (p_mask) else $error("mask test flags");
    property p_xor;
        logic [7:0] r, f;
        (go && opcode_in == 8'hB2, r = dst_data_in ^ src_data_in, f = flags_in) |-> ##4
            wr_en_out && result_out == r && flags_out[7:2] == {f[7], r == 8'h00, r[7], 1'b0, f[3:2]};
    endproperty
    a_xor: assert property (p_xor) else $error("xor result or flags");
    property p_stay;
        (cpu_stall_out && !int_req_in) [*3] |=> cpu_stall_out && !flags_we_out;
    endproperty
    a_stay: assert property (p_stay) else $error("wait left early");
    property p_wake;
        $rose(int_req_in) && cpu_stall_out |-> ##[1:5] done_out && !flags_we_out;
    endproperty
    a_wake: assert property (p_wake) else $error("wait not ended");
    property p_dma;
        (cpu_stall_out && dma_req_in) [*3] |-> dma_grant_out;
    endproperty
    a_dma: assert property (p_dma) else $error("dma held off");
    cover property (sh);
    cover property (lg);
    cover property (cpu_stall_out && dma_grant_out);
endmodule // ntl_exec_chk
bind ntl_exec ntl_exec_chk ntl_exec_chk_inst (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(start_in),
    .int_req_in(int_req_in),
    .dma_req_in(dma_req_in),
    .busy_out(busy_out),
    .opcode_in(opcode_in),
    .dst_data_in(dst_data_in),
    .src_data_in(src_data_in),
    .flags_in(flags_in),
    .result_out(result_out),
    .flags_out(flags_out),
    .wr_en_out(wr_en_out),
    .flags_we_out(flags_we_out),
    .done_out(done_out),
    .cpu_stall_out(cpu_stall_out),
    .dma_grant_out(dma_grant_out)
);
`default_nettype wire

/* dv/ntl_rf_model.sv */
// register file byte and flag register fed by the datapath
`timescale 1ns/1ps
`default_nettype none
module ntl_rf_model (
    input wire logic clk_in, rst_n_in, wr_in, fwe_in,
    input wire logic [7:0] data_in, flags_in,
    output logic [7:0] mem_out, flags_out
);
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            mem_out <= 8'h00;
            flags_out <= 8'h00;
        end else begin
            if (wr_in) mem_out <= data_in;
            if (fwe_in) flags_out <= flags_in;
        end
    end
endmodule // ntl_rf_model
`default_nettype wire

/* dv/tb_ntl_exec.sv */
// self-checking bench for the nibble/test/logic datapath
`timescale 1ns/1ps
`default_nettype none
module tb_ntl_exec;
    logic clk = 0, rst_n = 0, start = 0, irq = 0, dma = 0;
    logic [7:0] op = 0, d = 0, s = 0, f = 0, res, fl, mem, mf, em = 0, ef = 0;
    logic wr, fwe, done, busy, stall, grant, ill, sf, ind, imm;
    logic [1:0] nb;
    logic [31:0] rng = 32'h728b_8383;
    int miscompares = 0, comparisons = 0, n, i, k;
    ntl_exec ntl_exec_inst (.ref_clk_in(clk), .rst_n_in(rst_n), .start_in(start), .opcode_in(op),
        .dst_data_in(d), .src_data_in(s), .int_req_in(irq), .dma_req_in(dma), .flags_in(f),
        .result_out(res), .wr_en_out(wr), .flags_out(fl), .flags_we_out(fwe), .done_out(done),
        .bytes_out(nb), .src_first_out(sf), .indirect_out(ind), .immediate_out(imm),
        .illegal_out(ill),
        .busy_out(busy), .cpu_stall_out(stall), .dma_grant_out(grant));
    ntl_rf_model ntl_rf_model_inst (.clk_in(clk), .rst_n_in(rst_n), .wr_in(wr), .fwe_in(fwe),
        .data_in(res), .flags_in(fl), .mem_out(mem), .flags_out(mf));
    initial forever #20 clk = ~clk;
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function [7:0] code(input int j);
        code = j < 2 ? 8'hF0 + 8'(j) : {j < 7 ? 4'h6 : j < 12 ? 4'h7 : 4'hB, 4'(2 + (j - 2) % 5)};
    endfunction
    function [7:0] exp_val(input [7:0] o, input [7:0] dd, input [7:0] ss);
        exp_val = o[7:4] == 4'hF ? {dd[3:0], dd[7:4]} : o[7:4] == 4'h6 ? ~dd & ss :
            o[7:4] == 4'h7 ? dd & ss : dd ^ ss;
    endfunction
    function [7:0] exp_flg(input [7:0] o, input [7:0] r, input [7:0] ff);
        exp_flg = {ff[7], r == 8'h00, r[7], o[7:4] == 4'hF && ff[4], ff[3:0]};
    endfunction
    function [7:0] exp_dec(input [7:0] o);
        exp_dec = {3'h0, (o[3:0] > 4'h3) ? 2'h3 : 2'h2, (o[3:0] == 4'h4 || o[3:0] == 4'h5),
            (o[3:0] == 4'h1 || o[3:0] == 4'h3 || o[3:0] == 4'h5), (o[3:0] == 4'h6)};
    endfunction
    task chk(input [7:0] got, input [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wdone;
        n = 1;
        while (done !== 1'b1 && n < 20) begin
            @(negedge clk);
            start = 0;
            n++;
        end
        if (done !== 1'b1) begin
            miscompares++;
            end_of_test;
        end
    endtask
    task run(input [7:0] o, input [7:0] dd, input [7:0] ss, input [7:0] ff);
        logic [7:0] r, c;
        r = exp_val(o, dd, ss);
        ef = exp_flg(o, r, ff);
        c = (o[7:4] == 4'hF || o[3:0] == 4'h2) ? 8'h08 : 8'h0C;
        if (o[7:4] == 4'hF || o[7:4] == 4'hB) em = r;
        @(negedge clk);
        start = 1;
        op = o;
        d = dd;
        s = ss;
        f = ff;
        #1 chk({3'h0, nb, sf, ind, imm}, exp_dec(o));
        @(negedge clk);
        op = 8'hB2;
        d = ~dd;
        chk(8'(busy), 8'h01);
        wdone;
        chk({n[6:0], busy}, c);
        @(negedge clk);
        chk(mf, ef);
        chk(mem, em);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1;
        run(8'hF0, 8'h3E, 8'h00, 8'h90);
        run(8'hF1, 8'h00, 8'h55, 8'h6C);
        run(8'h62, 8'hC7, 8'h02, 8'hFC);
        run(8'h72, 8'hC7, 8'h02, 8'h00);
        for (k = 0; k < 3; k++) begin
            for (i = 0; i < 17; i++) begin
                rng = lfsr(rng);
                run(code(i), rng[7:0], rng[15:8], rng[23:16] & 8'hFC);
            end
        end
        @(negedge clk);
        start = 1;
        op = 8'h00;
        #1 chk(8'(ill), 8'h01);
        @(negedge clk);
        op = 8'h3F;
        @(negedge clk);
        start = 0;
        dma = 1;
        repeat (6) @(negedge clk);
        chk({6'h00, stall, grant}, 8'h03);
        irq = 1;
        wdone;
        chk({5'h00, stall, wr, fwe}, 8'h00);
        @(negedge clk);
        irq = 0;
        dma = 0;
        chk(mem, em);
        chk(mf, ef);
        end_of_test;
    end
endmodule // tb_ntl_exec
`default_nettype wire
